// ### hdl/mta_top.sv
// Purpose: macrocell register test access: preload, observe, power-up clear
// Assumes: tester drives pins; clk_sys is the fast sampling clock
// Notes:   pins pass two flip-flops before any logic reads them
`timescale 1ns/1ps

module mta_top (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    // test commands from dedicated inputs
    input  wire logic        preload_term,
    input  wire logic        observe_term,
    // device pin clock and latch gate
    input  wire logic        pin_clk,
    input  wire logic        latch_gate_n,
    // programmed configuration
    input  wire logic [15:0] polarity_low,
    input  wire logic [15:0] latch_sel,
    // normal function data and enables
    input  wire logic [15:0] func_d,
    input  wire logic [15:0] func_oe,
    // io pins
    input  wire logic [15:0] io_i,
    output logic      [15:0] io_o,
    output logic      [15:0] io_oe,
    // status
    output logic             pur_done,
    output logic      [1:0]  mode
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // one word for all pin inputs: two commands, pin clock and latch gate, then sixteen io pins
    logic [19:0] s1_q;
    logic [19:0] s2_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= '0;
            s2_q <= '0;
        end else if (clk_en) begin
            s1_q <= {preload_term, observe_term, pin_clk, latch_gate_n, io_i};
            s2_q <= s1_q;
        end
    end

    logic        pre_s;
    logic        obs_s;
    logic        clk_s;
    logic        gate_n_s;
    logic [15:0] io_s;
    assign pre_s    = s2_q[19];
    assign obs_s    = s2_q[18];
    assign clk_s    = s2_q[17];
    assign gate_n_s = s2_q[16];
    assign io_s     = s2_q[15:0];

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // command priority: observe overrides preload
    function automatic mta_pkg::mta_mode_e mta_decode_mode(
        input logic obs,
        input logic pre
    );
        mta_pkg::mta_mode_e m;
        m = mta_pkg::MTA_NORMAL;
        if (obs)
            m = mta_pkg::MTA_OBSERVE;
        else if (pre)
            m = mta_pkg::MTA_PRELOAD;
        return m;
    endfunction

    // pin level of a cell value through its programmed polarity
    function automatic logic [15:0] mta_pin_level(
        input logic [15:0] value,
        input logic [15:0] pol
    );
        return value ^ pol;
    endfunction

    // ------------------------------------------------------------
    // power-up clear timer
    // ------------------------------------------------------------
    logic [mta_pkg::PUR_CNT_W-1:0] pur_cnt_q;
    // pin clock edges are ignored while the clear window runs,
    // so no register can pick up a value before the clear ends
    logic                          pur_busy;
    assign pur_busy = (pur_cnt_q != mta_pkg::PUR_CNT_W'(mta_pkg::PUR_CYCLES - 1));
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            pur_cnt_q <= '0;
        else if (clk_en && pur_busy)
            pur_cnt_q <= pur_cnt_q + 10'h001;
    end

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    mta_pkg::mta_mode_e mode_d;
    always_comb begin
        mode_d = mta_decode_mode(obs_s, pre_s);
    end

    // ------------------------------------------------------------
    // pin clock edge and macrocell registers
    // ------------------------------------------------------------
    logic        clk_prev_q;
    logic        clk_rise;
    logic [15:0] reg_q;
    assign clk_rise = clk_s && !clk_prev_q && !pur_busy;

    // load strobes: observe mode ignores pin clock edges
    logic        load_pre;
    logic        load_func;
    assign load_pre  = clk_rise && (mode_d == mta_pkg::MTA_PRELOAD);
    assign load_func = clk_rise && (mode_d == mta_pkg::MTA_NORMAL);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            clk_prev_q <= 1'b0;
        else if (clk_en)
            clk_prev_q <= clk_s;
    end

    // register update: preload from pins or normal function
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_q <= mta_pkg::REG_RESET;
        end else if (clk_en) begin
            if (pur_busy)
                reg_q <= mta_pkg::REG_RESET;
            else if (load_pre)
                reg_q <= io_s;
            else if (load_func)
                reg_q <= func_d;
        end
    end

    // ------------------------------------------------------------
    // transparent latch cells
    // ------------------------------------------------------------
    logic [15:0] lat_q;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_cell
            mta_latch_cell u_cell (
                .clk_sys   (clk_sys),
                .rst_b     (rst_b),
                .clk_en    (clk_en),
                .d_in      (func_d[gi]),
                .gate_open (!gate_n_s),
                .q_out     (lat_q[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // output drive
    // ------------------------------------------------------------
    // latched cells take the latch model, registered cells the register
    logic [15:0] cell_val;
    assign cell_val = (reg_q & ~latch_sel) | (lat_q & latch_sel);

    // observe shows raw register values with every buffer on;
    // preload leaves the pins to the tester

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            io_o  <= 16'h0000;
            io_oe <= 16'h0000;
        end else if (clk_en) begin
            case (mode_d)
                mta_pkg::MTA_OBSERVE: begin
                    io_o  <= reg_q;
                    io_oe <= 16'hffff;
                end
                mta_pkg::MTA_PRELOAD: begin
                    io_o  <= mta_pin_level(reg_q, polarity_low);
                    io_oe <= 16'h0000; // pins are driven by tester
                end
                mta_pkg::MTA_NORMAL: begin
                    io_o  <= mta_pin_level(cell_val, polarity_low);
                    io_oe <= func_oe;
                end
                default: begin
                    io_o  <= 16'h0000;
                    io_oe <= 16'h0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    // registered copies so every top output comes from a flip-flop
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pur_done <= 1'b0;
            mode     <= 2'b00;
        end else if (clk_en) begin
            pur_done <= !pur_busy;
            mode     <= mode_d;
        end
    end
endmodule // mta_top

// ### hdl/mta_pkg.sv
// Purpose: constants shared by the macrocell test access block
// Assumes: 100 MHz clk_sys
// Notes:   sixteen macrocells, one register each
package mta_pkg;
    localparam int unsigned CELLS          = 16;
    localparam int unsigned CLK_PERIOD_PS  = 10000;
    // power-up clear completion time
    localparam int unsigned PUR_TIME_NS    = 10000;
    localparam int unsigned PUR_CYCLES     = (PUR_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned PUR_CNT_W      = 10;
    // combinatorial path through one transparent latch
    localparam int unsigned PTD_TIME_NS    = 28;
    localparam int unsigned PTD_CYCLES     = (PTD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // gate open to output through transparent latch
    localparam int unsigned GOL_TIME_NS    = 15;
    localparam int unsigned GOL_CYCLES     = (GOL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned DLY_W          = 3;
    localparam logic [15:0] REG_RESET      = 16'h0000;

    typedef enum logic [1:0] {
        MTA_NORMAL  = 2'b00,
        MTA_PRELOAD = 2'b01,
        MTA_OBSERVE = 2'b10
    } mta_mode_e;
endpackage

// ### hdl/mta_latch_cell.sv
// Purpose: one latched macrocell output timing model
// Assumes: inputs already synchronised to clk_sys
// Notes:   path delay and gate delay counted in cycles
`timescale 1ns/1ps
module mta_latch_cell (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic clk_en,
    // latch side
    input  wire logic d_in,
    input  wire logic gate_open,
    output logic      q_out
);
    logic [mta_pkg::DLY_W-1:0] path_cnt_q;
    logic [mta_pkg::DLY_W-1:0] gate_cnt_q;
    logic                      d_prev_q;
    logic                      path_ok;
    logic                      gate_ok;

    assign path_ok = (path_cnt_q == mta_pkg::DLY_W'(mta_pkg::PTD_CYCLES));
    assign gate_ok = (gate_cnt_q == mta_pkg::DLY_W'(mta_pkg::GOL_CYCLES));

    // age of latest input change
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            d_prev_q   <= 1'b0;
            path_cnt_q <= '0;
        end else if (clk_en) begin
            d_prev_q <= d_in;
            if (d_in != d_prev_q)
                path_cnt_q <= 3'h1;
            else if (!path_ok)
                path_cnt_q <= path_cnt_q + 3'h1;
        end
    end

    // time since the gate went transparent
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            gate_cnt_q <= '0;
        end else if (clk_en) begin
            if (!gate_open)
                gate_cnt_q <= '0;
            else if (!gate_ok)
                gate_cnt_q <= gate_cnt_q + 3'h1;
        end
    end

    // output follows at the later of both delays
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            q_out <= 1'b0;
        else if (clk_en && path_ok && gate_ok)
            q_out <= d_prev_q;
    end
endmodule // mta_latch_cell

// ### test/mta_top_monitor.sv
// Purpose: port checks for mta_top
// Assumes: one clk_sys domain, rst_b async low
// Notes:   age_q counts cycles since reset release
`timescale 1ns/1ps
module mta_top_monitor (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        clk_en,
    // commands and config
    input wire logic        preload_term,
    input wire logic        observe_term,
    input wire logic [15:0] polarity_low,
    // watched outputs
    input wire logic [15:0] io_o,
    input wire logic [15:0] io_oe,
    input wire logic        pur_done,
    input wire logic [1:0]  mode
);
    logic [10:0] age_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // saturating age since reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) age_q <= 11'h000;
        else if (clk_en && age_q != 11'h44c) age_q <= age_q + 11'h001;
    end
    a_observe_oe_on: assert property (mode == mta_pkg::MTA_OBSERVE |-> io_oe == 16'hffff)
        else $error("observe oe off");
    a_preload_oe_off: assert property (mode == mta_pkg::MTA_PRELOAD |-> io_oe == 16'h0000)
        else $error("preload oe on");
    a_observe_mode_entry: assert property ((observe_term && clk_en)[*4] |-> mode == mta_pkg::MTA_OBSERVE)
        else $error("observe not entered");
    a_preload_mode_entry: assert property ((preload_term && !observe_term && clk_en && pur_done)[*4]
        |-> mode == mta_pkg::MTA_PRELOAD) else $error("preload not entered");
    a_normal_mode_return: assert property ((!preload_term && !observe_term && clk_en)[*4]
        |-> mode == mta_pkg::MTA_NORMAL) else $error("normal not resumed");
    a_observe_io_hold: assert property (mode == 2'b10 && $past(mode) == 2'b10 |-> $stable(io_o))
        else $error("observe io moved");
    a_clear_time_bound: assert property (age_q >= 11'h3ed |-> pur_done)
        else $error("clear too long");
    a_clear_io_value: assert property (!pur_done && mode == 2'b00 && age_q >= 11'h003 |-> io_o == polarity_low)
        else $error("clear io wrong");
    c_observe: cover property (mode == mta_pkg::MTA_OBSERVE);
    c_preload: cover property (mode == mta_pkg::MTA_PRELOAD);
    c_clear: cover property ($rose(pur_done));
endmodule // mta_top_monitor
bind mta_top mta_top_monitor u_mon (.clk_sys, .rst_b, .clk_en, .preload_term, .observe_term, .polarity_low,
    .io_o, .io_oe, .pur_done, .mode);

// ### test/mta_tester.sv
// Purpose: tester model driving the test pins
// Assumes: callers enter tasks at a clk_sys rising edge
// Notes:   released pins show the inverse of last drive
`timescale 1ns/1ps
module mta_tester (
    // clock and observed pins
    input wire logic        clk_sys,
    input wire logic [15:0] io_o,
    // driven pins
    output logic            preload_term,
    output logic            observe_term,
    output logic            pin_clk,
    output logic     [15:0] io_i
);
    // idle levels, clock low after power-up
    initial begin
        preload_term = 1'b0;
        observe_term = 1'b0;
        pin_clk      = 1'b0;
        io_i         = 16'h0000;
    end
    // one pin clock pulse
    task automatic pulse_clk();
        pin_clk <= 1'b1;
        repeat (4) @(posedge clk_sys);
        pin_clk <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    // preload from a dedicated command input
    task automatic preload(input logic [15:0] v);
        preload_term <= 1'b1;
        io_i         <= v;
        repeat (4) @(posedge clk_sys);
        pulse_clk();
        io_i <= ~v;
        repeat (4) @(posedge clk_sys);
        preload_term <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask
    // observe: release pins, then command
    task automatic observe(output logic [15:0] v);
        io_i <= ~io_i;
        @(posedge clk_sys);
        observe_term <= 1'b1;
        repeat (5) @(posedge clk_sys);
        #1 v = io_o;
        @(posedge clk_sys);
        observe_term <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule // mta_tester

// ### test/mta_top_bench.sv
// Purpose: self-checking bench for mta_top
// Assumes: tester model drives command and pin inputs
// Notes:   polarity 00ff, clk_en held high
`timescale 1ns/1ps
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin mismatches++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, s); end end
module mta_top_bench;
    logic        clk_sys, rst_b, clk_en, preload_term, observe_term, pin_clk, latch_gate_n, pur_done;
    logic [1:0]  mode;
    logic [15:0] polarity_low, latch_sel, func_d, func_oe, io_i, io_o, io_oe, seen;
    int          mismatches, tests_run, n;
    mta_top uut (.clk_sys, .rst_b, .clk_en, .preload_term, .observe_term, .pin_clk, .latch_gate_n,
        .polarity_low, .latch_sel, .func_d, .func_oe, .io_i, .io_o, .io_oe, .pur_done, .mode);
    mta_tester u_tester (.clk_sys, .io_o, .preload_term, .observe_term, .pin_clk, .io_i);
    // clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // clock edges inside the clear window are ignored
    task automatic t_power_up();
        repeat (3) @(posedge clk_sys);
        u_tester.pulse_clk();
        #1 `CHK("clear io", 16'h00ff, io_o)
        for (n = 0; n < 1100 && pur_done !== 1'b1; n++) @(posedge clk_sys);
        `CHK("pur_done", 1'b1, pur_done)
        repeat (2) @(posedge clk_sys);
        #1 `CHK("io after clear", 16'h00ff, io_o)
        $display("test power_up done");
    endtask
    task automatic t_preload(input logic [15:0] v);
        @(posedge clk_sys);
        u_tester.preload(v);
        #1 `CHK("preload io", v ^ 16'h00ff, io_o)
        `CHK("mode", 2'b00, mode)
        `CHK("oe", 16'hffff, io_oe)
        $display("test preload done");
    endtask
    // observe shows raw register, then normal loads resume
    task automatic t_observe(input logic [15:0] v);
        @(posedge clk_sys);
        u_tester.observe(seen);
        `CHK("observe io", v, seen)
        #1 `CHK("io after observe", v ^ 16'h00ff, io_o)
        @(posedge clk_sys);
        func_d <= 16'h1234;
        func_oe <= 16'hf0f0;
        u_tester.pulse_clk();
        #1 `CHK("normal io", 16'h12cb, io_o)
        `CHK("normal oe", 16'hf0f0, io_oe)
        $display("test observe done");
    endtask
    // late open, then early open on cell 15
    task automatic t_latch();
        @(posedge clk_sys);
        latch_sel <= 16'h8000;
        func_d <= 16'h0000;
        latch_gate_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        latch_gate_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        func_d <= 16'h8000;
        repeat (10) @(posedge clk_sys);
        #1 `CHK("latch held", 1'b0, io_o[15])
        @(posedge clk_sys);
        latch_gate_n <= 1'b0;
        @(posedge clk_sys);
        #1 `CHK("latch soon", 1'b0, io_o[15])
        repeat (8) @(posedge clk_sys);
        #1 `CHK("latch late", 1'b1, io_o[15])
        @(posedge clk_sys);
        latch_gate_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        func_d <= 16'h0000;
        latch_gate_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 `CHK("early soon", 1'b1, io_o[15])
        repeat (8) @(posedge clk_sys);
        #1 `CHK("early late", 1'b0, io_o[15])
        $display("test latch done");
    endtask
    // watchdog
    initial begin
        #60000;
        mismatches++;
        end_of_test();
    end
    // main sequence
    initial begin
        {rst_b, mismatches, tests_run} = '0;
        {clk_en, latch_gate_n, polarity_low, latch_sel} = {2'b11, 16'h00ff, 16'h0000};
        {func_d, func_oe} = {16'hffff, 16'hffff};
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_power_up();
        t_preload(16'ha5c3);
        t_preload(16'h5a3c);
        t_observe(16'h5a3c);
        t_latch();
        end_of_test();
    end
endmodule // mta_top_bench
